// [logic/dcw_host.sv]
`timescale 1ns/1ps
module dcw_host
  import dcw_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire logic [13:0] frame_i,
  input wire logic zc_window_i,
  input wire logic wiper_reset_req_i,
  input wire logic shutdown_req_i,
  dcw_link_if.host link,
  output logic busy_o,
  output logic [13:0] chain_out_o
);
  import dcw_pkg::*;
  dcw_state_t state_ff, nxt_state;
  logic [3:0] div_ff, nxt_div;
  logic [4:0] bit_ff, nxt_bit;
  logic [13:0] frame_ff, nxt_frame;
  logic [13:0] rx_ff, nxt_rx;
  logic sclk_ff, nxt_sclk;
  logic cs_n_ff, nxt_cs_n;
  logic busy_ff, nxt_busy;
  logic sdo_s1_ff, sdo_s2_ff;
  logic zc_s1_ff, zc_s2_ff;
  logic tick;
  logic rst_n_ff, shutdown_n_n_ff;

  // A slow divided clock leaves room for the pulled-up return line.
  // Divided serial clock
  assign tick = (div_ff == 4'(CLK_DIV - 1));

  always_comb
  begin
    nxt_state = state_ff;
    nxt_div = tick ? CNT_ZERO : 4'(div_ff + 4'h1);
    nxt_bit = bit_ff;
    nxt_frame = frame_ff;
    nxt_rx = rx_ff;
    nxt_sclk = sclk_ff;
    nxt_cs_n = cs_n_ff;
    nxt_busy = busy_ff;
    unique case (state_ff)
      DCW_IDLE:
      begin
        nxt_sclk = 1'b0;
        nxt_cs_n = 1'b1;
        if (start_i)
        begin
          // Far word sits in the high bits
          nxt_frame = frame_i;
          nxt_bit = BIT_ZERO;
          nxt_busy = 1'b1;
          nxt_cs_n = 1'b0;
          nxt_state = DCW_SHIFT;
        end
        else if ((rst_n_ff == wiper_reset_req_i) || (shutdown_n_n_ff == shutdown_req_i))
        begin
          // The device only sees pin changes on link clock edges, so give it some.
          nxt_bit = BIT_ZERO;
          nxt_busy = 1'b1;
          nxt_state = DCW_DONE;
        end
      end
      DCW_SHIFT:
      begin
        if (tick)
        begin
          nxt_sclk = !sclk_ff;
          if (sclk_ff)
          begin
            nxt_frame = {frame_ff[12:0], 1'b0};
            nxt_bit = 5'(bit_ff + 5'h01);
            // The return bit settled after the last rise, well before this fall.
            nxt_rx = {rx_ff[12:0], sdo_s2_ff};
            if (bit_ff == 5'(FRAME_BITS - 1))
              nxt_state = DCW_GAP;
          end
        end
      end
      DCW_GAP:
      begin
        // Select held low until window, then released
        if (zc_s2_ff)
        begin
          nxt_cs_n = 1'b1;
          nxt_bit = BIT_ZERO;
          nxt_state = DCW_DONE;
        end
      end
      DCW_DONE:
      begin
        // Keep the clock toggling a little so the device sees the select rise.
        if (tick)
        begin
          nxt_sclk = !sclk_ff;
          if (sclk_ff)
            nxt_bit = 5'(bit_ff + 5'h01);
        end
        if (bit_ff == 5'h03)
        begin
          nxt_busy = 1'b0;
          nxt_state = DCW_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_ff <= DCW_IDLE;
      div_ff <= CNT_ZERO;
      bit_ff <= BIT_ZERO;
      frame_ff <= 14'h0000;
      rx_ff <= 14'h0000;
      sclk_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      busy_ff <= 1'b0;
      sdo_s1_ff <= 1'b1;
      sdo_s2_ff <= 1'b1;
      zc_s1_ff <= 1'b0;
      zc_s2_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      div_ff <= nxt_div;
      bit_ff <= nxt_bit;
      frame_ff <= nxt_frame;
      rx_ff <= nxt_rx;
      sclk_ff <= nxt_sclk;
      cs_n_ff <= nxt_cs_n;
      busy_ff <= nxt_busy;
      sdo_s1_ff <= link.sdo_line;
      sdo_s2_ff <= sdo_s1_ff;
      zc_s1_ff <= zc_window_i;
      zc_s2_ff <= zc_s1_ff;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rst_n_ff <= 1'b1;
      shutdown_n_n_ff <= 1'b0;
    end
    else
    begin
      rst_n_ff <= !wiper_reset_req_i;
      shutdown_n_n_ff <= !shutdown_req_i;
    end
  end

  assign link.sclk = sclk_ff;
  assign link.cs_n = cs_n_ff;
  assign link.sdi = frame_ff[13];
  assign link.rst_n = rst_n_ff;
  assign link.shutdown_n_n = shutdown_n_n_ff;
  assign busy_o = busy_ff;
  assign chain_out_o = rx_ff;
endmodule : dcw_host

// [logic/dcw_pkg.sv]
package dcw_pkg;
  localparam int WORD_W = 7;
  localparam logic [6:0] MIDSCALE = 7'h40;
  localparam logic [6:0] ZERO_SCALE = 7'h00;
  localparam logic [6:0] FULL_SCALE = 7'h7f;
  localparam int CHAIN_LEN = 2;
  localparam int FRAME_BITS = WORD_W * CHAIN_LEN;
  localparam int CLK_DIV = 4;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [4:0] BIT_ZERO = 5'h00;
  typedef enum logic [1:0] {DCW_IDLE, DCW_SHIFT, DCW_GAP, DCW_DONE} dcw_state_t;
endpackage : dcw_pkg

// [logic/dcw_link_if.sv]
`timescale 1ns/1ps
interface dcw_link_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic rst_n;
  logic shutdown_n_n;
  logic sdo_o;
  logic sdo_oe_n;
  wire sdo_line;
  // Open-drain line with an external pull-up: low only while the driver is enabled.
  assign sdo_line = (!sdo_oe_n && !sdo_o) ? 1'b0 : 1'b1;
  modport dev (input sclk, input cs_n, input sdi, input rst_n, input shutdown_n_n,
    output sdo_o, output sdo_oe_n);
  modport host (output sclk, output cs_n, output sdi, output rst_n, output shutdown_n_n,
    input sdo_line);
endinterface : dcw_link_if

// [logic/dcw_device.sv]
`timescale 1ns/1ps
// Contract
// - Seven-bit word, MSB first, rising edge.
// - Chip select rise copies shift register.
// - Reset low forces midscale, clears output.
// - Shutdown opens A, mutes output, keeps programming.
// - Output repeats previous frame's input bits.
// - Output only pulls low or releases.
// - Host shifts seven bits per device.
// - Farthest device's word goes first.
// - Chip select low until frame done.
// - Host may slow clock for chains.
// - Host gates chip select with window.
// - Gated chip select uses one pulse, held low until the window.
// - Muted start: shutdown held, zero code.
// - Wiper code is unsigned 0 to 127.
module dcw_device
  import dcw_pkg::*;
(
  input wire logic wiper_cs_n_i,
  dcw_link_if.dev link,
  output logic [6:0] wiper_code_o,
  output logic term_a_open_o,
  output logic wiper_to_b_o
);
  import dcw_pkg::*;
  logic [6:0] serial_shift_register_ff;
  logic [6:0] nxt_serial_shift_register;
  logic [6:0] wiper_setting_latch_ff;
  logic [6:0] nxt_wiper_setting_latch;
  logic sdo_bit_ff;
  logic nxt_sdo_bit;
  logic cs_q_ff;
  logic rst_q_ff;
  logic shutdown_n_s1_ff;
  logic shutdown_n_s2_ff;
  logic cs_rise;
  logic rst_rise;

  // The port stays a spare; the device sees chip select on the link only.
  logic unused_cs;
  assign unused_cs = wiper_cs_n_i;

  // Edges of the slow control pins are seen on the link clock, so they need a
  // few clock edges while chip select is high; the host supplies those.
  assign cs_rise = link.cs_n && !cs_q_ff;
  assign rst_rise = link.rst_n && !rst_q_ff;

  always_comb
  begin
    nxt_serial_shift_register = serial_shift_register_ff;
    nxt_wiper_setting_latch = wiper_setting_latch_ff;
    nxt_sdo_bit = sdo_bit_ff;
    if (!link.rst_n)
    begin
      nxt_wiper_setting_latch = MIDSCALE;
      nxt_sdo_bit = 1'b0;
    end
    else
    begin
      if (!link.cs_n)
      begin
        nxt_serial_shift_register = {serial_shift_register_ff[5:0], link.sdi};
        nxt_sdo_bit = serial_shift_register_ff[6];
      end
      if (rst_rise && link.cs_n)
      begin
        nxt_wiper_setting_latch = MIDSCALE;
      end
      else if (cs_rise)
      begin
        nxt_wiper_setting_latch = serial_shift_register_ff;
      end
    end
  end

  always_ff @(posedge link.sclk)
  begin
    serial_shift_register_ff <= nxt_serial_shift_register;
    wiper_setting_latch_ff <= nxt_wiper_setting_latch;
    sdo_bit_ff <= nxt_sdo_bit;
    cs_q_ff <= link.cs_n;
    rst_q_ff <= link.rst_n;
    shutdown_n_s1_ff <= link.shutdown_n_n;
    shutdown_n_s2_ff <= shutdown_n_s1_ff;
  end

  assign link.sdo_o = 1'b0;
  assign link.sdo_oe_n = sdo_bit_ff | !shutdown_n_s2_ff;

  assign wiper_code_o = shutdown_n_s2_ff ? wiper_setting_latch_ff : ZERO_SCALE;
  assign term_a_open_o = !shutdown_n_s2_ff;
  assign wiper_to_b_o = !shutdown_n_s2_ff;
endmodule : dcw_device

// [dv/dcw_link_assertions.sv]
`timescale 1ns/1ps
module dcw_link_assertions (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic rst_n,
  input wire logic shutdown_n_n,
  input wire logic sdo_o,
  input wire logic sdo_oe_n,
  input wire logic sdo_line
);
  default clocking cb @(posedge sclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_shift8;
    (!cs_n && shutdown_n_n) [*8];
  endsequence
  sequence s_frame14;
    !cs_n [*7] ##1 !cs_n [*7] ##1 cs_n;
  endsequence
  AST_SDO_LOW: assert property (sdo_o == 1'b0)
    else $error("sdo drives high");
  AST_SDO_DELAY: assert property (s_shift8 ##1 shutdown_n_n |-> sdo_line == $past(sdi, 8))
    else $error("sdo not delayed input");
  AST_SDO_MOVE: assert property ($changed(sdo_oe_n) && $past(rst_n) && $past(shutdown_n_n, 2)
    && $past(shutdown_n_n, 3) |-> !$past(cs_n))
    else $error("sdo moved without shift");
  AST_SDO_IDLE: assert property ((cs_n && shutdown_n_n && rst_n) [*4] |-> $stable(sdo_oe_n))
    else $error("sdo moved while idle");
  AST_SHUTDOWN_N_OFF: assert property (!shutdown_n_n [*3] |-> sdo_oe_n)
    else $error("sdo on in shutdown");
  AST_RST_CLR: assert property (disable iff (1'b0) !rst_n [*2] |-> sdo_oe_n == !$past(shutdown_n_n, 2))
    else $error("sdo not cleared in reset");
  AST_FRAME14: assert property ($fell(cs_n) |-> s_frame14)
    else $error("frame not fourteen bits");
  AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n [*2])
    else $error("select gap too short");
endmodule : dcw_link_assertions

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
  import dcw_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic start_i = 1'b0;
  logic [13:0] frame_i = 14'h0000;
  logic zc_i = 1'b1;
  logic rreq_i = 1'b0;
  logic sreq_i = 1'b1;
  logic busy_o;
  logic [13:0] chain_o;
  logic [6:0] code_o;
  logic a_open_o;
  logic to_b_o;
  int num_errors = 0;
  int n_tests = 0;
  logic [6:0] prev_w;
  logic [6:0] codes [5] = '{7'h00, 7'h01, 7'h40, 7'h7f, 7'h2a};
  dcw_link_if i_dcw_link_if ();
  dcw_host i_dcw_host (.clk_i(clk_i), .srst_i(srst_i), .start_i(start_i), .frame_i(frame_i),
    .zc_window_i(zc_i), .wiper_reset_req_i(rreq_i), .shutdown_req_i(sreq_i),
    .link(i_dcw_link_if.host), .busy_o(busy_o), .chain_out_o(chain_o));
  dcw_device i_dcw_device (.wiper_cs_n_i(1'b1), .link(i_dcw_link_if.dev),
    .wiper_code_o(code_o), .term_a_open_o(a_open_o), .wiper_to_b_o(to_b_o));
  dcw_link_assertions u_chk (.sclk(i_dcw_link_if.sclk), .cs_n(i_dcw_link_if.cs_n),
    .sdi(i_dcw_link_if.sdi), .rst_n(i_dcw_link_if.rst_n), .shutdown_n_n(i_dcw_link_if.shutdown_n_n),
    .sdo_o(i_dcw_link_if.sdo_o), .sdo_oe_n(i_dcw_link_if.sdo_oe_n),
    .sdo_line(i_dcw_link_if.sdo_line));
  initial
  begin
    forever #50 clk_i = ~clk_i;
  end
  task automatic print_verdict();
    $display("Checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  // Sampling on the falling edge keeps clear of the updates launched by the rising edge.
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy_o !== lvl)
    begin
      @(negedge clk_i);
      n++;
      if (n > 2000)
      begin
        num_errors++;
        print_verdict();
      end
    end
  endtask : wait_busy
  task automatic start(input logic [13:0] f);
    @(posedge clk_i);
    frame_i <= f;
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
  endtask : start
  task automatic send(input logic [13:0] f);
    start(f);
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask : send
  initial
  begin
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    send({FULL_SCALE, ZERO_SCALE});
    chk("flags", 14'h0003, {12'h000, a_open_o, to_b_o});
    send({ZERO_SCALE, 7'h55});
    chk("code", 14'h0000, {7'h00, code_o});
    @(posedge clk_i);
    sreq_i <= 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk("code", 14'h0055, {7'h00, code_o});
    chk("flags", 14'h0000, {12'h000, a_open_o, to_b_o});
    prev_w = 7'h55;
    foreach (codes[i])
    begin
      send({~codes[i], codes[i]});
      chk("chain", {prev_w, ~codes[i]}, chain_o);
      chk("code", {7'h00, codes[i]}, {7'h00, code_o});
      prev_w = codes[i];
    end
    start({7'h00, 7'h33});
    zc_i <= 1'b0;
    repeat (300) @(negedge clk_i);
    chk("held", {7'h00, 7'h2a}, {7'h00, code_o});
    chk("busy", 14'h0001, {13'h0000, busy_o});
    @(posedge clk_i);
    zc_i <= 1'b1;
    wait_busy(1'b0);
    chk("code", 14'h0033, {7'h00, code_o});
    @(posedge clk_i);
    rreq_i <= 1'b1;
    send({7'h00, 7'h11});
    chk("code", {7'h00, MIDSCALE}, {7'h00, code_o});
    @(posedge clk_i);
    rreq_i <= 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk("code", {7'h00, MIDSCALE}, {7'h00, code_o});
    print_verdict();
  end
endmodule : tb
